// File: hdl/rctwp_top.sv
// rc trim write protect: apb slave, nonvolatile trim load, protect and trim registers
//
// Functional notes
// [RULE1] protect writes take effect only with write_inhibit 0; it reads 1
// [RULE2] lock and trim write enable change only while protect_enable is 1
// [RULE3] protect_enable follows accepted writes; reset clears it
// [RULE4] trim writes are ignored while the lock is set
// [RULE5] lock blocks protect writes, cannot be written back to 0; reset only
// [RULE6] lock sets only on write_inhibit 0, lock 1, protect_enable already 1
// [RULE7] trim writes need lock 0 and trim write enable 1
// [RULE8] trim write enable clears on reset or gated write of 0
// [RULE9] four low protect bits read 1, writes ignored
// [RULE10] software rewrites protect with full-byte moves, not bit operations
// [RULE11] flash variant loads trim from nonvolatile memory right after reset
// [RULE12] new trim drives the oscillator the cycle after the write
// [RULE13] trim is two's complement, sign bit 7, low two bits zero
// [RULE14] without a nonvolatile load trim resets to zero
// [RULE15] flash variant returns an undefined value on trim reads
// [RULE16] blocked writes give no error and change nothing
`timescale 1ns/100ps
module rctwp_top
  import rctwp_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1,
  parameter logic [TRIM_W-1:0] TRIM_READ_FILL = 8'h00
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nonvolatile trim source
  output logic nv_load_req,
  input wire logic nv_load_ack,
  input wire logic [TRIM_W-1:0] nv_load_data,
  // oscillator
  output logic [TRIM_W-1:0] osc_trim
);

  // ****************************************************
  // bus decode
  // ****************************************************
  logic acc_phase;
  logic sel_prot;
  logic sel_trim;
  logic mapped;
  logic done;
  logic wr_prot;
  logic wr_trim;
  logic load_done;
  logic [7:0] wdata8;
  logic [31:0] next_prdata;
  logic next_pready;
  rctwp_load_t load_state;
  rctwp_prot_t prot;
  rctwp_nv_t nv;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction

  // fixed bits are rebuilt on each read, never stored, so no write reaches them
  function automatic logic [31:0] prot_word(input rctwp_prot_t p);
    prot_word = {24'h000000, PROT_WRI_READ, p.protect_enable, p.trim_lock,
                 p.trim_write_enable, PROT_RESERVED_READ};
  endfunction

  function automatic logic [31:0] trim_word(input logic [TRIM_W-1:0] t);
    trim_word = {24'h000000, t};
  endfunction

  assign acc_phase = psel && penable;
  assign sel_prot = addr_hit(paddr, OFF_TRIM_PROTECT_CONTROL);
  assign sel_trim = addr_hit(paddr, OFF_OSCILLATOR_TRIM_VALUE);
  assign mapped = sel_prot || sel_trim;
  assign done = acc_phase && pready;
  assign wdata8 = pwdata[7:0];
  // writes land only at the completing edge
  assign wr_prot = done && pwrite && sel_prot;
  assign wr_trim = done && pwrite && sel_trim;
  assign load_done = (load_state == LD_DONE);

  // ****************************************************
  // nonvolatile load after reset
  // ****************************************************
  // bus held off until the trim has been loaded, so software never races it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_state <= LD_REQUEST;
    end else begin
      case (load_state)
        LD_REQUEST: begin
          if (!HAS_FLASH || nv_load_ack) begin
            load_state <= LD_DONE; // see [RULE11] [RULE14]
          end
        end
        LD_DONE: begin
          load_state <= LD_DONE;
        end
        default: begin
          load_state <= LD_REQUEST;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_load_req <= 1'b0;
    end else begin
      nv_load_req <= HAS_FLASH && (load_state == LD_REQUEST) && !nv_load_ack; // see [RULE11]
    end
  end

  assign nv = '{valid: HAS_FLASH && (load_state == LD_REQUEST) && nv_load_ack,
                data: nv_load_data};

  // ****************************************************
  // register blocks
  // ****************************************************
  rctwp_protect u_rctwp_protect (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr_prot),
    .wdata(wdata8),
    .prot(prot)
  );

  rctwp_trim u_rctwp_trim (
    .pclk(pclk),
    .presetn(presetn),
    .nv(nv),
    .wr(wr_trim),
    .wdata(wdata8),
    .prot(prot),
    .trim(osc_trim)
  );

  // ****************************************************
  // apb answer
  // ****************************************************
  // one wait state keeps pready a flop; access phase is two cycles
  assign next_pready = acc_phase && !pready && load_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= next_pready;
    end
  end

  // blocked writes to a mapped register answer without error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pready && !mapped; // see [RULE16]
    end
  end

  always_comb begin
    next_prdata = '0;
    if (next_pready && !pwrite) begin
      if (sel_prot) begin
        next_prdata = prot_word(prot); // see [RULE1] [RULE9]
      end else if (sel_trim) begin
        // loaded factory trim is not exposed to software
        next_prdata = trim_word(HAS_FLASH ? TRIM_READ_FILL : osc_trim); // see [RULE15]
      end
    end
  end

  // idle cycles read as zero, so a stale word never lingers on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wdata_wri;
  logic wdata_pe;
  logic wdata_lock;
  logic [TRIM_W-1:0] wdata_trim;
  assign wdata_wri = wdata8[BIT_WRITE_INHIBIT];
  assign wdata_pe = wdata8[BIT_PROTECT_ENABLE];
  assign wdata_lock = wdata8[BIT_TRIM_LOCK];
  assign wdata_trim = wdata8 & TRIM_WRITE_MASK;
  logic wdata_twe;
  logic [TRIM_W-1:0] nv_trim;
  assign wdata_twe = wdata8[BIT_TRIM_WRITE_ENABLE];
  assign nv_trim = nv.data & TRIM_WRITE_MASK;

  a_prot_read_fixed: assert property ( // see [RULE1] [RULE9]
    next_pready && !pwrite && sel_prot |=>
      prdata[BIT_WRITE_INHIBIT] && (prdata[3:0] == PROT_RESERVED_READ))
    else $error("protect read lost fixed one bits");

  a_wri_blocks_write: assert property ( // see [RULE1]
    wr_prot && wdata_wri |=> $stable(prot))
    else $error("protect changed on inhibited write");

  a_pe_follows_write: assert property ( // see [RULE3]
    wr_prot && !wdata_wri && !prot.trim_lock |=> prot.protect_enable == $past(wdata_pe))
    else $error("protect enable not taken from write");

  a_gate_by_pe: assert property ( // see [RULE2]
    $changed(prot.trim_write_enable) || $rose(prot.trim_lock) |->
      $past(prot.protect_enable))
    else $error("gated bit changed without protect enable");

  a_lock_sticky: assert property ( // see [RULE5]
    prot.trim_lock |=> prot.trim_lock && $stable(prot.protect_enable)
      && $stable(prot.trim_write_enable))
    else $error("lock cleared or protect changed while locked");

  a_lock_set_cause: assert property ( // see [RULE6]
    wr_prot && !wdata_wri && wdata_lock && prot.protect_enable |=> prot.trim_lock)
    else $error("lock did not set on qualified write");

  a_lock_blocks_trim: assert property ( // see [RULE4]
    wr_trim && prot.trim_lock |=> $stable(osc_trim))
    else $error("trim changed while locked");

  a_trim_needs_twe: assert property ( // see [RULE7] [RULE16]
    wr_trim && !prot.trim_write_enable |=> $stable(osc_trim))
    else $error("trim changed without write enable");

  a_trim_applied_next: assert property ( // see [RULE12] [RULE13]
    wr_trim && !prot.trim_lock && prot.trim_write_enable |=>
      osc_trim == $past(wdata_trim))
    else $error("trim not applied one cycle after write");

  a_trim_low_zero: assert property ( // see [RULE13]
    osc_trim[1:0] == 2'h0)
    else $error("trim low bits not zero");

  a_no_answer_loading: assert property ( // see [RULE11]
    !load_done |-> !pready && !pslverr)
    else $error("bus answered before trim load");

  a_answer_bound: assert property ( // see [RULE16]
    acc_phase && load_done && !pready |=> pready ##1 !pready)
    else $error("apb answer not in one wait state");

  a_mapped_no_err: assert property ( // see [RULE16]
    pready && mapped |-> !pslverr)
    else $error("error on mapped register");

  a_load_req_level: assert property ( // see [RULE11]
    HAS_FLASH && !load_done && !nv_load_ack |=> nv_load_req)
    else $error("load request not held while loading");

  a_load_req_drop: assert property ( // see [RULE11]
    nv_load_ack && !load_done |=> !nv_load_req && load_done)
    else $error("load request not dropped after ack");

  a_load_once: assert property ( // see [RULE11]
    load_done |=> load_done && !nv_load_req)
    else $error("load repeated without reset");

  a_trim_from_load: assert property ( // see [RULE11] [RULE13]
    nv.valid |=> osc_trim == $past(nv_trim))
    else $error("loaded trim not applied");

  a_trim_hold_idle: assert property ( // see [RULE16]
    !nv.valid && !wr_trim |=> $stable(osc_trim))
    else $error("trim changed without a write");

  a_trim_write_gate: assert property ( // see [RULE4] [RULE7]
    $changed(osc_trim) |-> $past(nv.valid) ||
      ($past(wr_trim) && $past(prot.trim_write_enable) && !$past(prot.trim_lock)))
    else $error("trim changed through a closed gate");

  a_trim_read_fill: assert property ( // see [RULE15]
    HAS_FLASH && next_pready && !pwrite && sel_trim |=> prdata == trim_word(TRIM_READ_FILL))
    else $error("trim read exposed stored value");

  a_prot_hold_idle: assert property ( // see [RULE16]
    !wr_prot |=> $stable(prot))
    else $error("protect changed without a write");

  a_prot_read_live: assert property ( // see [RULE1] [RULE9]
    next_pready && !pwrite && sel_prot |=> prdata == prot_word($past(prot)))
    else $error("protect read word wrong");

  a_twe_clear_write: assert property ( // see [RULE8]
    wr_prot && !wdata_wri && !wdata_twe && prot.protect_enable && !prot.trim_lock |=>
      !prot.trim_write_enable)
    else $error("trim write enable not cleared");

  a_lock_rise_cause: assert property ( // see [RULE6]
    $rose(prot.trim_lock) |-> $past(wr_prot) && !$past(wdata_wri) && $past(wdata_lock))
    else $error("lock set without a qualified write");

  a_lock_write_ignored: assert property ( // see [RULE5]
    wr_prot && prot.trim_lock |=> $stable(prot))
    else $error("locked protect register written");

  a_unmapped_err: assert property ( // see [RULE16]
    next_pready && !mapped |=> pready && pslverr)
    else $error("unmapped access without error");

  a_ready_pulse: assert property ( // see [RULE16]
    pready |=> !pready)
    else $error("pready longer than one cycle");

  a_no_ready_idle: assert property ( // see [RULE16]
    !acc_phase |=> !pready)
    else $error("pready without access phase");

  a_err_with_ready: assert property ( // see [RULE16]
    pslverr |-> pready)
    else $error("error without pready");

  a_idle_data_zero: assert property ( // see [RULE15]
    !pready |-> prdata == '0)
    else $error("read data outside answer cycle");

  // ****************************************************
  // covers
  // ****************************************************
  c_load_done: cover property (nv.valid);
  c_lock_set: cover property ($rose(prot.trim_lock));
  c_trim_written: cover property (wr_trim && prot.trim_write_enable && !prot.trim_lock);
  c_trim_blocked: cover property (wr_trim && prot.trim_lock);
  c_unmapped: cover property (pready && pslverr);

endmodule // rctwp_top

// File: hdl/rctwp_pkg.sv
// package: register map, field layout and state types of the rc trim protect block
package rctwp_pkg;

  // ****************************************************
  // register map (byte addresses on the apb bus)
  // ****************************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_TRIM_PROTECT_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_OSCILLATOR_TRIM_VALUE = 12'h004;

  // ****************************************************
  // trim_protect_control fields
  // ****************************************************
  localparam int BIT_WRITE_INHIBIT = 7;
  localparam int BIT_PROTECT_ENABLE = 6;
  localparam int BIT_TRIM_LOCK = 5;
  localparam int BIT_TRIM_WRITE_ENABLE = 4;
  localparam logic [3:0] PROT_RESERVED_READ = 4'hF;
  localparam logic PROT_WRI_READ = 1'b1;

  // ****************************************************
  // oscillator_trim_value fields
  // ****************************************************
  localparam int TRIM_W = 8;
  localparam int BIT_TRIM_SIGN = 7;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h00;
  localparam logic [TRIM_W-1:0] TRIM_WRITE_MASK = 8'hFC;
  localparam logic [TRIM_W-1:0] TRIM_MIN = 8'h80;
  localparam logic [TRIM_W-1:0] TRIM_MAX = 8'h7C;
  localparam logic [TRIM_W-1:0] TRIM_STEP = 8'h04;

  // ****************************************************
  // types
  // ****************************************************
  typedef struct packed {
    logic protect_enable;
    logic trim_lock;
    logic trim_write_enable;
  } rctwp_prot_t;

  localparam rctwp_prot_t PROT_RESET = '{1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic valid;
    logic [TRIM_W-1:0] data;
  } rctwp_nv_t;

  typedef enum logic [1:0] {
    LD_REQUEST,
    LD_DONE
  } rctwp_load_t;

endpackage

// File: hdl/rctwp_protect.sv
// protect register: write inhibit gate, protect enable, sticky lock, trim write enable
`timescale 1ns/100ps
module rctwp_protect
  import rctwp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write strobe from the bus slave
  input wire logic wr,
  input wire logic [7:0] wdata,
  // state
  output rctwp_prot_t prot
);

  logic accept;
  logic protect_enable;
  logic trim_lock;
  logic trim_write_enable;

  // writes count only with write_inhibit at 0, and never once locked
  assign accept = wr && !wdata[BIT_WRITE_INHIBIT] && !trim_lock; // see [RULE1] [RULE5]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_enable <= 1'b0; // see [RULE3]
    end else if (accept) begin
      protect_enable <= wdata[BIT_PROTECT_ENABLE]; // see [RULE3]
    end
  end

  // lock only sets, gated by the protect enable held before this write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_lock <= 1'b0; // see [RULE5]
    end else if (accept && protect_enable && wdata[BIT_TRIM_LOCK]) begin
      trim_lock <= 1'b1; // see [RULE2] [RULE6]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_write_enable <= 1'b0; // see [RULE8]
    end else if (accept && protect_enable) begin
      trim_write_enable <= wdata[BIT_TRIM_WRITE_ENABLE]; // see [RULE2] [RULE8]
    end
  end

  // one driver for the whole struct; field order matches the type
  assign prot = {protect_enable, trim_lock, trim_write_enable};

endmodule // rctwp_protect

// File: hdl/rctwp_trim.sv
// trim register: nonvolatile load and gated software writes, drives the oscillator
`timescale 1ns/100ps
module rctwp_trim
  import rctwp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // load from nonvolatile memory
  input rctwp_nv_t nv,
  // write strobe from the bus slave
  input wire logic wr,
  input wire logic [TRIM_W-1:0] wdata,
  input rctwp_prot_t prot,
  // trim to the oscillator
  output logic [TRIM_W-1:0] trim
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim <= TRIM_RESET; // see [RULE14]
    end else if (nv.valid) begin
      trim <= nv.data & TRIM_WRITE_MASK; // see [RULE11] [RULE13]
    end else if (wr && !prot.trim_lock && prot.trim_write_enable) begin
      // low two bits stay zero: steps of four
      trim <= wdata & TRIM_WRITE_MASK; // see [RULE4] [RULE7] [RULE12] [RULE13]
    end
  end

endmodule // rctwp_trim

// File: dv/rctwp_bench.sv
// self-checking testbench of the rc trim write protect block
`timescale 1ns/100ps
module rctwp_bench;
  import rctwp_pkg::*;

  // ****************************************************
  // signals and instance
  // ****************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic nv_load_req;
  logic nv_load_ack = 1'b0;
  logic [TRIM_W-1:0] nv_load_data = 8'h00;
  logic [TRIM_W-1:0] osc_trim;
  int fail_count = 0;
  int checked = 0;
  localparam logic [ADDR_W-1:0] P = OFF_TRIM_PROTECT_CONTROL;
  localparam logic [ADDR_W-1:0] T = OFF_OSCILLATOR_TRIM_VALUE;
  // fill differs from any trim used below, so a leaked trim shows up
  localparam logic [TRIM_W-1:0] FILL = 8'hA5;

  always #2 pclk = ~pclk;

  rctwp_top #(.HAS_FLASH(1'b1), .TRIM_READ_FILL(FILL)) u_rctwp_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nv_load_req(nv_load_req), .nv_load_ack(nv_load_ack), .nv_load_data(nv_load_data),
    .osc_trim(osc_trim));

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; only the watchdog ends a wait for pready
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk({31'h0, err}, 32'h0, "write error");
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic err;
    apb(1'b0, a, 8'h00, v, err);
    chk(v, exp, "read data");
  endtask

  // reset, then answer the nonvolatile load with d
  task automatic do_reset(input logic [7:0] d);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    chk({24'h0, osc_trim}, 32'h0, "trim in reset");
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk({31'h0, nv_load_req}, 32'h1, "load request");
    @(posedge pclk);
    nv_load_ack <= 1'b1;
    nv_load_data <= d;
    @(posedge pclk);
    nv_load_ack <= 1'b0;
    nv_load_data <= ~d;
    #1;
    chk({24'h0, osc_trim}, {24'h0, d & 8'hFC}, "loaded trim");
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    do_reset(8'h57);
    rd(P, 32'h8F);
    rd(T, {24'h0, FILL});
    $display("test reset done");
  endtask

  task automatic t_gate;
    wr(P, 8'hF0);
    rd(P, 32'h8F);
    wr(P, 8'h10);
    rd(P, 32'h8F);
    wr(P, 8'h40);
    rd(P, 32'hCF);
    wr(P, 8'h50);
    rd(P, 32'hDF);
    wr(P, 8'h00);
    rd(P, 32'h8F);
    $display("test protect gate done");
  endtask

  task automatic t_trim;
    logic [7:0] wv [5];
    wv = '{8'h7F, 8'h80, 8'hFC, 8'h04, 8'h01};
    wr(P, 8'h40);
    wr(P, 8'h50);
    foreach (wv[i]) begin
      wr(T, wv[i]);
      chk({24'h0, osc_trim}, {24'h0, wv[i] & 8'hFC}, "trim write");
    end
    rd(T, {24'h0, FILL});
    wr(P, 8'h40);
    wr(T, 8'h20);
    chk({24'h0, osc_trim}, 32'h00, "trim disabled");
    $display("test trim done");
  endtask

  task automatic t_lock;
    // protect enable is still set from the trim test; clear it first
    wr(P, 8'h00);
    rd(P, 32'h8F);
    wr(P, 8'h20);
    rd(P, 32'h8F);
    wr(P, 8'h60);
    rd(P, 32'hCF);
    wr(P, 8'h50);
    wr(T, 8'h44);
    wr(P, 8'h70);
    rd(P, 32'hFF);
    wr(T, 8'h10);
    chk({24'h0, osc_trim}, 32'h44, "locked trim");
    wr(P, 8'h40);
    wr(P, 8'h00);
    rd(P, 32'hFF);
    do_reset(8'h33);
    rd(P, 32'h8F);
    $display("test lock done");
  endtask

  task automatic t_unmapped;
    logic [31:0] v;
    logic err;
    apb(1'b1, 12'h008, 8'hFF, v, err);
    chk({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, 12'h008, 8'h00, v, err);
    chk({31'h0, err}, 32'h1, "unmapped read");
    rd(P, 32'h8F);
    $display("test unmapped done");
  endtask

  // ****************************************************
  // verdict and run
  // ****************************************************
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #40000;
    fail_count++;
    $display("ERROR %0t: watchdog expired", $time);
    results;
  end

  initial begin
    t_reset;
    t_gate;
    t_trim;
    t_lock;
    t_unmapped;
    results;
  end
endmodule // rctwp_bench
